// [hdl/icr_regs.vh]
// constants for the local control port and data path option registers
// assumes a 5 ns system clock and a nominal 40 ns oscillator period
`ifndef ICR_REGS_VH
`define ICR_REGS_VH

// ******************************
// register offsets
// ******************************
`define ICR_ADDR_PORT_CTRL    8'h17
`define ICR_ADDR_CLK_HIGH     8'h18
`define ICR_ADDR_CLK_LOW      8'h19
`define ICR_ADDR_DATA_PATH    8'h1a

// ******************************
// reset values
// ******************************
`define ICR_RST_PORT_CTRL     8'h1e
`define ICR_RST_CLK_HIGH      8'h7f
`define ICR_RST_CLK_LOW       8'h7f
`define ICR_RST_DATA_PATH     8'h01

// ******************************
// field positions
// ******************************
`define ICR_PASS_ALL_BIT      7
`define ICR_HOLD_MSB          6
`define ICR_HOLD_LSB          4
`define ICR_FILT_MSB          3
`define ICR_FILT_LSB          0
`define ICR_AUX_AUDIO_BIT     3
`define ICR_WIDE_WORD_BIT     1
`define ICR_SURROUND_BIT      0

// ******************************
// timing
// ******************************
`define ICR_CLK_PERIOD_NS     5
`define ICR_OSC_PERIOD_NS     40
`define ICR_OSC_TICK_CYC      (`ICR_OSC_PERIOD_NS / `ICR_CLK_PERIOD_NS)
`define ICR_FILT_STEP_NS      5
`define ICR_FILT_STEP_CYC     (`ICR_FILT_STEP_NS / `ICR_CLK_PERIOD_NS)
`define ICR_PHASE_EXTRA       5
`define ICR_STRAP_SETTLE      3

`endif

// [hdl/icr_glitch_filter.v]
// glitch filter for one synchronised bus line
// assumes the input already passed a two-stage synchroniser
`timescale 1ns/1ps

module icr_glitch_filter (
  input  wire       clk,      // system clock
  input  wire       rst_n,    // async reset, active low
  input  wire [3:0] depth,    // longest rejected pulse, in 5 ns steps
  input  wire       din,      // synchronised line level
  output reg        dout      // filtered line level
);

  // ******************************
  // mismatch run counter
  // ******************************
  reg  [3:0] run_ff;          // consecutive cycles din differs from dout

  // a change is taken only after it outlasts depth cycles, so any pulse
  // of depth cycles or less never reaches dout
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 4'h0;
      dout   <= 1'b1;         // idle bus reads high
    end else if (din == dout) begin
      run_ff <= 4'h0;         // reload on every settled level
    end else if (run_ff >= depth) begin
      dout   <= din;          // change outlasted the window
      run_ff <= 4'h0;
    end else begin
      run_ff <= run_ff + 4'h1;
    end
  end

endmodule // icr_glitch_filter

// [hdl/icr_cfg_regs.v]
// control port and data path option registers of the serializer,
// with the local bus input conditioning and master clock timing
// assumes register accesses arrive from the serial control engine on
// the same clock; bus pins and the strap pin are asynchronous
`timescale 1ns/1ps
`include "icr_regs.vh"

module icr_cfg_regs #(
  parameter NUM_PORTS = 2                 // link ports sharing the bank
) (
  input  wire       REF_CLK,              // 200 MHz system clock
  input  wire       RESET_N,              // async reset, active low
  input  wire [7:0] REG_ADDR,             // register address
  input  wire [7:0] REG_WDATA,            // register write data
  input  wire       REG_WR,               // write strobe, one cycle
  input  wire       REG_RD,               // read strobe, one cycle
  output reg  [7:0] REG_RDATA,            // read data
  output reg        REG_RVALID,           // read data valid pulse
  input  wire       SECOND_PORT_SELECT,   // steer per-port bits to port 1
  input  wire       ADDR_VALID,           // target ID captured, pulse
  input  wire [6:0] ADDR_ID,              // captured target ID
  input  wire [6:0] OWN_ID,               // this device's target ID
  input  wire [6:0] REMOTE_DES_ID,        // remote deserializer ID
  input  wire [6:0] REMOTE_TGT_ID,        // configured remote target ID
  output reg        FWD_VALID,            // forwarding decision pulse
  output reg  [1:0] FWD_PORT,             // ports that forward the access
  input  wire       SCL_I,                // bus clock pin level
  input  wire       SDA_I,                // bus data pin level
  output reg        SCL_INT,              // filtered clock to engine
  output reg        SDA_INT,              // filtered, held data to engine
  input  wire       MASTER_EN,            // run the master clock
  input  wire       TGT_DATA_LOADED,      // target drove SDA, pulse
  output reg        TGT_SCL_RELEASE,      // setup met, stretch ends, pulse
  output reg        SCL_O,                // clock pin output value
  output reg        SCL_OE_N,             // clock pin drive, active low
  input  wire       STRAP_PIN,            // aux audio strap pin level
  input  wire       AUX_CTRL_WR,          // bridge config writes aux bit
  input  wire       AUX_CTRL_VAL,         // value for aux bit
  input  wire       REPEATER,             // device is in a repeater
  input  wire       I2S_DET_VALID,        // in-band detection result pulse
  input  wire       I2S_DET_SURROUND,     // detected multichannel mode
  output reg        WIDE_WORD_MODE,       // 28-bit word mode
  output reg        SURROUND_EN,          // multichannel audio enabled
  output reg        ISLAND_XPORT,         // data-island transport in use
  output reg        AUX_AUDIO_EN          // aux audio channel enabled
);

  // ******************************
  // constants and state codes
  // ******************************
  localparam [11:0] TICK_W  = `ICR_OSC_TICK_CYC;   // sys cycles per tick
  localparam [11:0] EXTRA_W = `ICR_PHASE_EXTRA;    // extra osc periods
  localparam [5:0]  TICK_H  = `ICR_OSC_TICK_CYC;   // same, hold width
  localparam [7:0]  RST_CTRL = `ICR_RST_PORT_CTRL; // control reset image
  localparam [7:0]  RST_DPTH = `ICR_RST_DATA_PATH; // option reset image
  localparam [1:0]  M_IDLE  = 2'h0;                // clock released
  localparam [1:0]  M_HIGH  = 2'h1;                // high phase
  localparam [1:0]  M_LOW   = 2'h2;                // low phase

  // ******************************
  // register storage
  // ******************************
  reg  [NUM_PORTS-1:0] pass_all_ff;    // pass-all, one bit per port
  reg  [2:0]  hold_ff;                 // sda hold, 40 ns units
  reg  [3:0]  filt_ff;                 // glitch depth, 5 ns units
  reg  [7:0]  high_ff;                 // master clock high time
  reg  [7:0]  low_ff;                  // master clock low time
  reg         wide_ff;                 // word mode
  reg         surr_ff;                 // surround transport
  reg         aux_ff;                  // aux audio control copy
  wire        port_sel;                // selected port index
  reg  [7:0]  nxt_rdata;               // read mux

  assign port_sel = SECOND_PORT_SELECT & (NUM_PORTS > 1);

  // ******************************
  // register writes
  // ******************************
  // software writes, plus hardware override of the surround bit
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // fields are cut from the reset images so widths match exactly
      pass_all_ff <= {NUM_PORTS{RST_CTRL[`ICR_PASS_ALL_BIT]}};
      hold_ff     <= RST_CTRL[`ICR_HOLD_MSB:`ICR_HOLD_LSB];
      filt_ff     <= RST_CTRL[`ICR_FILT_MSB:`ICR_FILT_LSB];
      high_ff     <= `ICR_RST_CLK_HIGH;
      low_ff      <= `ICR_RST_CLK_LOW;
      wide_ff     <= RST_DPTH[`ICR_WIDE_WORD_BIT];
      surr_ff     <= RST_DPTH[`ICR_SURROUND_BIT];
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `ICR_ADDR_PORT_CTRL: begin
            pass_all_ff[port_sel] <= REG_WDATA[`ICR_PASS_ALL_BIT];
            hold_ff <= REG_WDATA[`ICR_HOLD_MSB:`ICR_HOLD_LSB];
            filt_ff <= REG_WDATA[`ICR_FILT_MSB:`ICR_FILT_LSB];
          end
          `ICR_ADDR_CLK_HIGH: begin
            high_ff <= REG_WDATA;
          end
          `ICR_ADDR_CLK_LOW: begin
            low_ff <= REG_WDATA;
          end
          `ICR_ADDR_DATA_PATH: begin
            // bit 3 is read-only, so only the low bits store
            wide_ff <= REG_WDATA[`ICR_WIDE_WORD_BIT];
            surr_ff <= REG_WDATA[`ICR_SURROUND_BIT];
          end
          default: begin
            // unmapped writes are dropped
          end
        endcase
      end
      // detection lands after the write, so hardware wins a tie
      if (REPEATER && I2S_DET_VALID) begin
        surr_ff <= I2S_DET_SURROUND;
      end
    end
  end

  // ******************************
  // register reads
  // ******************************
  // reserved bits read zero; unmapped addresses read zero
  always @* begin
    nxt_rdata = 8'h00;
    case (REG_ADDR)
      `ICR_ADDR_PORT_CTRL: begin
        nxt_rdata = {pass_all_ff[port_sel], hold_ff, filt_ff};
      end
      `ICR_ADDR_CLK_HIGH: begin
        nxt_rdata = high_ff;
      end
      `ICR_ADDR_CLK_LOW: begin
        nxt_rdata = low_ff;
      end
      `ICR_ADDR_DATA_PATH: begin
        nxt_rdata = {4'h0, aux_ff, 1'b0, wide_ff, surr_ff};
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // read data one cycle after the strobe, then held
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= nxt_rdata;
      end
    end
  end

  // ******************************
  // strap capture for aux audio
  // ******************************
  reg  [1:0]  strap_sync_ff;           // two-stage synchroniser
  reg  [1:0]  strap_cnt_ff;            // settle count after release
  reg         strap_done_ff;           // strap already taken

  // the strap is caught a few clocks after release, never in reset
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_sync_ff <= 2'h0;
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      aux_ff        <= 1'b0;
    end else begin
      strap_sync_ff <= {strap_sync_ff[0], STRAP_PIN};
      if (!strap_done_ff) begin
        if (strap_cnt_ff == `ICR_STRAP_SETTLE) begin
          aux_ff        <= strap_sync_ff[1];
          strap_done_ff <= 1'b1;
        end else begin
          strap_cnt_ff <= strap_cnt_ff + 2'h1;
        end
      end else if (AUX_CTRL_WR) begin
        aux_ff <= AUX_CTRL_VAL;                // mirrored control follows
      end
    end
  end

  // ******************************
  // data path option outputs
  // ******************************
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WIDE_WORD_MODE <= 1'b0;
      SURROUND_EN    <= 1'b0;
      ISLAND_XPORT   <= 1'b0;
      AUX_AUDIO_EN   <= 1'b0;
    end else begin
      WIDE_WORD_MODE <= wide_ff;
      SURROUND_EN    <= surr_ff;
      // surround has no other transport, so it always forces islands
      ISLAND_XPORT   <= surr_ff;
      AUX_AUDIO_EN   <= aux_ff;
    end
  end

  // ******************************
  // forwarding decision
  // ******************************
  wire [NUM_PORTS-1:0] nxt_fwd;        // per-port forward flag
  wire        id_remote;               // matches a remote ID
  wire        id_own;                  // matches this device

  assign id_remote = (ADDR_ID == REMOTE_DES_ID) || (ADDR_ID == REMOTE_TGT_ID);
  assign id_own    = (ADDR_ID == OWN_ID);

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp = gp + 1) begin : g_fwd
      // pass-all widens the set to anything not aimed at us
      assign nxt_fwd[gp] = pass_all_ff[gp] ? !id_own
                                           : id_remote;
    end
  endgenerate

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FWD_VALID <= 1'b0;
      FWD_PORT  <= 2'h0;
    end else begin
      FWD_VALID <= ADDR_VALID;
      if (ADDR_VALID) begin
        FWD_PORT <= {{(2-NUM_PORTS){1'b0}}, nxt_fwd};
      end
    end
  end

  // ******************************
  // bus input conditioning
  // ******************************
  reg  [1:0]  scl_sync_ff;             // clock pin synchroniser
  reg  [1:0]  sda_sync_ff;             // data pin synchroniser
  wire [1:0]  line_sync;               // second stages only
  wire [1:0]  line_filt;               // filtered levels
  reg         sda_pend_ff;             // sda level waiting on hold
  reg  [5:0]  hold_cnt_ff;             // hold countdown

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_I};
      sda_sync_ff <= {sda_sync_ff[0], SDA_I};
    end
  end

  assign line_sync = {sda_sync_ff[1], scl_sync_ff[1]};

  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_filt
      icr_glitch_filter u_filt (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .depth (filt_ff),
        .din   (line_sync[gp]),
        .dout  (line_filt[gp])
      );
    end
  endgenerate

  // sda is held back so a data edge near the clock falling edge is not
  // mistaken for a start or stop condition
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sda_pend_ff <= 1'b1;
      hold_cnt_ff <= 6'h00;
      SDA_INT     <= 1'b1;
      SCL_INT     <= 1'b1;
    end else begin
      SCL_INT <= line_filt[0];
      if (line_filt[1] != sda_pend_ff) begin
        sda_pend_ff <= line_filt[1];
        hold_cnt_ff <= {3'h0, hold_ff} * TICK_H;
      end else if (hold_cnt_ff != 6'h00) begin
        hold_cnt_ff <= hold_cnt_ff - 6'h01;
      end else begin
        SDA_INT <= sda_pend_ff;
      end
    end
  end

  // ******************************
  // master clock and target stretch
  // ******************************
  reg  [1:0]  mst_state_ff;            // master phase state
  reg  [1:0]  nxt_mst_state;           // next phase state
  reg  [11:0] mst_cnt_ff;              // phase countdown
  reg  [11:0] nxt_mst_cnt;             // next phase countdown
  reg         stretch_ff;              // target holds clock low
  reg  [11:0] setup_cnt_ff;            // setup countdown
  wire [11:0] high_len;                // high phase length in cycles
  wire [11:0] low_len;                 // low phase length in cycles

  // phase widths include five extra oscillator periods
  assign high_len = ({4'h0, high_ff} + EXTRA_W) * TICK_W;
  assign low_len  = ({4'h0, low_ff} + EXTRA_W) * TICK_W;

  // phase sequencer; the counter reloads on entry to the low and high phases
  always @* begin
    nxt_mst_state = mst_state_ff;
    nxt_mst_cnt   = mst_cnt_ff;
    case (mst_state_ff)
      M_IDLE: begin
        if (MASTER_EN) begin
          nxt_mst_state = M_LOW;
          nxt_mst_cnt   = low_len;
        end
      end
      M_LOW: begin
        if (mst_cnt_ff > 12'h001) begin
          nxt_mst_cnt = mst_cnt_ff - 12'h001;
        end else if (!stretch_ff) begin
          // a stretching target pauses the master in its low phase
          nxt_mst_state = M_HIGH;
          nxt_mst_cnt   = high_len;
        end
      end
      M_HIGH: begin
        if (mst_cnt_ff > 12'h001) begin
          nxt_mst_cnt = mst_cnt_ff - 12'h001;
        end else if (MASTER_EN) begin
          nxt_mst_state = M_LOW;
          nxt_mst_cnt   = low_len;
        end else begin
          nxt_mst_state = M_IDLE;                  // stop with clock high
        end
      end
      default: begin
        nxt_mst_state = M_IDLE;
        nxt_mst_cnt   = 12'h000;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mst_state_ff <= M_IDLE;
      mst_cnt_ff   <= 12'h000;
    end else begin
      mst_state_ff <= nxt_mst_state;
      mst_cnt_ff   <= nxt_mst_cnt;
    end
  end

  // target side: data is on sda, clock stays low for the setup time
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stretch_ff      <= 1'b0;
      setup_cnt_ff    <= 12'h000;
      TGT_SCL_RELEASE <= 1'b0;
    end else begin
      TGT_SCL_RELEASE <= 1'b0;
      if (TGT_DATA_LOADED) begin
        stretch_ff   <= 1'b1;
        setup_cnt_ff <= low_len;
      end else if (stretch_ff) begin
        if (setup_cnt_ff > 12'h001) begin
          setup_cnt_ff <= setup_cnt_ff - 12'h001;
        end else begin
          stretch_ff      <= 1'b0;
          TGT_SCL_RELEASE <= 1'b1;
        end
      end
    end
  end

  // open-drain clock: only ever pulled low, released otherwise
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SCL_O    <= 1'b0;
      SCL_OE_N <= 1'b1;
    end else begin
      SCL_O    <= 1'b0;
      SCL_OE_N <= !((nxt_mst_state == M_LOW) ||
                    (TGT_DATA_LOADED || (stretch_ff &&
                     setup_cnt_ff > 12'h001)));
    end
  end

endmodule // icr_cfg_regs

// [test/icr_cfg_regs_chk.sv]
// checker for the config register bank, sees only its ports
// assumes one clock domain and the bind below
`timescale 1ns/1ps
module icr_cfg_regs_chk (
  input wire       REF_CLK,          // system clock
  input wire       RESET_N,          // async reset, active low
  input wire [7:0] REG_ADDR,         // register address
  input wire [7:0] REG_WDATA,        // write data
  input wire       REG_WR,           // write strobe
  input wire       REG_RD,           // read strobe
  input wire [7:0] REG_RDATA,        // read data
  input wire       REG_RVALID,       // read valid
  input wire       ADDR_VALID,       // target id captured
  input wire [6:0] ADDR_ID,          // captured id
  input wire [6:0] OWN_ID,           // own id
  input wire [6:0] REMOTE_DES_ID,    // remote deserializer id
  input wire [6:0] REMOTE_TGT_ID,    // remote target id
  input wire       FWD_VALID,        // forward decision
  input wire [1:0] FWD_PORT,         // forwarding ports
  input wire       MASTER_EN,        // master clock run
  input wire       TGT_DATA_LOADED,  // target data driven
  input wire       TGT_SCL_RELEASE,  // stretch release
  input wire       SCL_OE_N,         // clock drive, active low
  input wire       REPEATER,         // repeater mode
  input wire       I2S_DET_VALID,    // detection pulse
  input wire       I2S_DET_SURROUND, // detected mode
  input wire       SURROUND_EN,      // surround enabled
  input wire       ISLAND_XPORT      // island transport
);
  // ******************************
  // helper logic
  // ******************************
  reg  [7:0]  lo_sh_ff;  // shadow of the low time register
  reg  [7:0]  hi_sh_ff;  // shadow of the high time register
  reg  [11:0] lo_cnt_ff; // cycles the clock is driven low
  reg  [11:0] hi_cnt_ff; // cycles the clock is released
  reg  [11:0] st_cnt_ff; // cycles since target data loaded
  reg         run_ff;    // master has pulled the clock low since enabled
  wire [11:0] lo_len = ({4'h0, lo_sh_ff} + 12'h005) << 3;
  wire [11:0] hi_len = ({4'h0, hi_sh_ff} + 12'h005) << 3;
  // shadows follow writes so phase lengths are known here
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lo_sh_ff  <= 8'h7f;
      hi_sh_ff  <= 8'h7f;
      lo_cnt_ff <= 12'h000;
      hi_cnt_ff <= 12'h000;
      st_cnt_ff <= 12'h000;
      run_ff    <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == 8'h19) lo_sh_ff <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h18) hi_sh_ff <= REG_WDATA;
      lo_cnt_ff <= SCL_OE_N ? 12'h000 : lo_cnt_ff + 12'h001;
      hi_cnt_ff <= SCL_OE_N ? hi_cnt_ff + 12'h001 : 12'h000;
      st_cnt_ff <= TGT_DATA_LOADED ? 12'h000 : st_cnt_ff + 12'h001;
      run_ff    <= MASTER_EN & (run_ff | ~SCL_OE_N);
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ******************************
  // assertions
  // ******************************
  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read strobe got no valid");
  a_read_unmapped: assert property ((REG_RD &&
    (REG_ADDR < 8'h17 || REG_ADDR > 8'h1a)) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_fwd_own_id: assert property ((ADDR_VALID &&
    ADDR_ID == OWN_ID && ADDR_ID != REMOTE_DES_ID &&
    ADDR_ID != REMOTE_TGT_ID) |=> (FWD_VALID && FWD_PORT == 2'b00))
    else $error("own id forwarded");
  a_fwd_remote_id: assert property ((ADDR_VALID &&
    ADDR_ID != OWN_ID && (ADDR_ID == REMOTE_DES_ID ||
    ADDR_ID == REMOTE_TGT_ID)) |=> (FWD_VALID && FWD_PORT == 2'b11))
    else $error("remote id not forwarded");
  a_low_phase: assert property (
    ($rose(SCL_OE_N) && run_ff) |-> lo_cnt_ff == lo_len)
    else $error("master low phase length wrong");
  a_high_phase: assert property (
    ($fell(SCL_OE_N) && run_ff) |-> hi_cnt_ff == hi_len)
    else $error("master high phase length wrong");
  a_tgt_setup: assert property (TGT_SCL_RELEASE |->
    st_cnt_ff == lo_len)
    else $error("target release at wrong time");
  a_surr_write: assert property ((REG_WR &&
    REG_ADDR == 8'h1a && !(REPEATER && I2S_DET_VALID)) |-> ##2
    SURROUND_EN == $past(REG_WDATA[0], 2))
    else $error("surround bit not applied");
  a_surr_override: assert property ((REPEATER &&
    I2S_DET_VALID) |-> ##2 SURROUND_EN == $past(I2S_DET_SURROUND, 2))
    else $error("surround override not applied");
  a_island_only: assert property (SURROUND_EN |-> ISLAND_XPORT)
    else $error("surround without island transport");
  c_forward: cover property (ADDR_VALID ##1 FWD_PORT == 2'b01);
  c_master: cover property ($rose(SCL_OE_N) && run_ff);
  c_stretch: cover property (TGT_SCL_RELEASE);
endmodule // icr_cfg_regs_chk

bind icr_cfg_regs icr_cfg_regs_chk i_icr_cfg_regs_chk (.*);

// [test/icr_bus_model.sv]
// local bus model: pull-ups, a far-side clock source and a glitcher
// assumes the design only ever pulls the clock line low
`timescale 1ns/1ps
module icr_bus_model (
  input  wire scl_o,     // clock value from the design
  input  wire scl_oe_n,  // clock drive, low while driving
  input  wire frame,     // far side runs its clock
  input  wire glitch,    // short low pulse on the clock
  input  wire sda_drv_n, // far side pulls data low
  output wire scl,       // resolved clock wire
  output wire sda        // resolved data wire
);
  reg link_clk = 1'b1; // 80 ns clock, parked high outside frames
  // free phase against the system clock, stands still between frames
  initial begin
    #13;
    forever #40 link_clk = frame ? ~link_clk : 1'b1;
  end
  // open drain with pull-ups: any party may pull low
  assign scl = (scl_oe_n | scl_o) & link_clk & ~glitch;
  assign sda = sda_drv_n;
endmodule // icr_bus_model

// [test/icr_cfg_regs_tb.sv]
// testbench for the config register bank
// assumes the bus model and the bound checker are compiled with it
`timescale 1ns/1ps
module icr_cfg_regs_tb;
  reg        REF_CLK = 1'b0;
  reg        RESET_N = 1'b0;
  reg  [7:0] REG_ADDR = 8'h00;
  reg  [7:0] REG_WDATA = 8'h00;
  reg        REG_WR = 1'b0, REG_RD = 1'b0, SECOND_PORT_SELECT = 1'b0;
  reg        ADDR_VALID = 1'b0, MASTER_EN = 1'b0, TGT_DATA_LOADED = 1'b0;
  reg  [6:0] ADDR_ID = 7'h00, OWN_ID = 7'h1a;
  reg  [6:0] REMOTE_DES_ID = 7'h2c, REMOTE_TGT_ID = 7'h3d;
  reg        STRAP_PIN = 1'b1, AUX_CTRL_WR = 1'b0, AUX_CTRL_VAL = 1'b0;
  reg        REPEATER = 1'b0, I2S_DET_VALID = 1'b0, I2S_DET_SURROUND = 1'b0;
  reg        frame = 1'b0, glitch = 1'b0, sda_n = 1'b1, low_seen;
  wire [7:0] REG_RDATA;
  wire [1:0] FWD_PORT;
  wire       REG_RVALID, FWD_VALID, SCL_I, SDA_I, SCL_INT, SDA_INT;
  wire       TGT_SCL_RELEASE, SCL_O, SCL_OE_N, WIDE_WORD_MODE;
  wire       SURROUND_EN, ISLAND_XPORT, AUX_AUDIO_EN;
  integer    mismatches = 0, check_count = 0, n0, n1, k;
  integer    wire_rises = 0, int_rises = 0;

  icr_cfg_regs i_icr_cfg_regs (.*);
  icr_bus_model i_icr_bus_model (.scl_o(SCL_O), .scl_oe_n(SCL_OE_N),
    .frame(frame), .glitch(glitch), .sda_drv_n(sda_n), .scl(SCL_I),
    .sda(SDA_I));

  initial forever #2.5 REF_CLK = ~REF_CLK;
  // edge counts on the wire and behind the input conditioning
  always @(posedge SCL_I) wire_rises = wire_rises + 1;
  always @(posedge SCL_INT) int_rises = int_rises + 1;

  // ******************************
  // tasks
  // ******************************
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick;
    begin
      @(posedge REF_CLK);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      tick;
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      tick;
      REG_WR = 1'b0;
    end
  endtask
  // answer shows in the cycle after the strobe edge
  task rd(input [7:0] a, input [7:0] exp);
    begin
      tick;
      REG_ADDR = a;
      REG_RD = 1'b1;
      tick;
      REG_RD = 1'b0;
      chk(REG_RVALID, 1'b1);
      chk(REG_RDATA, exp);
    end
  endtask
  task fwd(input [6:0] id, input [1:0] exp);
    begin
      tick;
      ADDR_ID = id;
      ADDR_VALID = 1'b1;
      tick;
      ADDR_VALID = 1'b0;
      chk(FWD_VALID, 1'b1);
      chk(FWD_PORT, exp);
    end
  endtask
  function pick(input [1:0] sel);
    pick = sel == 2'd0 ? SCL_INT : sel == 2'd1 ? SDA_INT : TGT_SCL_RELEASE;
  endfunction
  // bounded wait for a level, returns the cycles taken
  task meas(input [1:0] sel, input lvl, output integer n);
    begin
      n = 0;
      while (pick(sel) !== lvl && n < 4000) begin
        tick;
        n = n + 1;
      end
      if (n == 4000) begin
        mismatches = mismatches + 1;
        stop_test;
      end
    end
  endtask
  task pulse_clk(input integer w);
    begin
      glitch = 1'b1;
      repeat (w) tick;
      glitch = 1'b0;
      low_seen = 1'b0;
      repeat (16) begin
        tick;
        low_seen = low_seen | ~SCL_INT;
      end
    end
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    repeat (16) @(posedge REF_CLK);
    #1 RESET_N = 1'b1;
    repeat (8) tick;
    rd(8'h17, 8'h1e);
    rd(8'h18, 8'h7f);
    rd(8'h19, 8'h7f);
    rd(8'h1a, 8'h09);
    rd(8'h1b, 8'h00);
    chk({SURROUND_EN, ISLAND_XPORT, AUX_AUDIO_EN}, 3'b111);
    fwd(7'h55, 2'b00);
    fwd(REMOTE_TGT_ID, 2'b11);
    fwd(REMOTE_DES_ID, 2'b11);
    wr(8'h17, 8'h9e);
    fwd(7'h55, 2'b01);
    fwd(OWN_ID, 2'b00);
    SECOND_PORT_SELECT = 1'b1;
    rd(8'h17, 8'h1e);
    wr(8'h17, 8'h9e);
    fwd(7'h55, 2'b11);
    rd(8'h17, 8'h9e);
    SECOND_PORT_SELECT = 1'b0;
    wr(8'h1a, 8'hff);
    rd(8'h1a, 8'h0b);
    chk({WIDE_WORD_MODE, SURROUND_EN}, 2'b11);
    wr(8'h1a, 8'h00);
    rd(8'h1a, 8'h08);
    chk({WIDE_WORD_MODE, SURROUND_EN}, 2'b00);
    // detection beats a write landing on the same edge
    REPEATER = 1'b1;
    tick;
    {I2S_DET_VALID, I2S_DET_SURROUND, REG_WR} = 3'b111;
    REG_WDATA = 8'h00;
    tick;
    {I2S_DET_VALID, REG_WR} = 2'b00;
    rd(8'h1a, 8'h09);
    REPEATER = 1'b0;
    tick;
    AUX_CTRL_WR = 1'b1;
    tick;
    AUX_CTRL_WR = 1'b0;
    rd(8'h1a, 8'h01);
    wr(8'h17, 8'h03);
    pulse_clk(3);
    chk(low_seen, 1'b0);
    pulse_clk(4);
    chk(low_seen, 1'b1);
    wr(8'h17, 8'h00);
    sda_n = 1'b0;
    meas(2'd1, 1'b0, n0);
    wr(8'h17, 8'h20);
    sda_n = 1'b1;
    meas(2'd1, 1'b1, n1);
    chk(n1 - n0, 12'd16);
    wire_rises = 0;
    int_rises = 0;
    frame = 1'b1;
    repeat (320) tick;
    frame = 1'b0;
    repeat (40) tick;
    chk(int_rises, wire_rises);
    wr(8'h19, 8'h02);
    wr(8'h18, 8'h03);
    MASTER_EN = 1'b1;
    meas(2'd0, 1'b0, k);
    meas(2'd0, 1'b1, n0);
    chk(n0, 12'd56);
    meas(2'd0, 1'b0, n1);
    chk(n1, 12'd64);
    MASTER_EN = 1'b0;
    repeat (300) tick;
    chk(SCL_OE_N, 1'b1);
    chk(SCL_O, 1'b0);
    TGT_DATA_LOADED = 1'b1;
    tick;
    TGT_DATA_LOADED = 1'b0;
    meas(2'd2, 1'b1, n0);
    chk(n0, 12'd56);
    stop_test;
  end
endmodule // icr_cfg_regs_tb
